// ===== hdl/pmbus_status_flags.sv
// latched status flags of a multi-phase power module, with alert and link port
// assumes: events arrive on sys_clk; requests arrive on link_clk, one at a time
`timescale 1ns/1ps

// Overview of operation
// - over-temperature fault latches temperature bit 7
// - over-temperature warning latches temperature bit 6
// - unsupported bits read zero, save live vendor bit 6 (self_busy), ignore writes
// - write-one clears a flag; clear command clears all
// - invalid command code latches communication bit 7
// - invalid payload latches communication bit 6
// - packet check failure latches communication bit 5
// - memory check error latches communication bit 4
// - core logic error latches communication bit 3
// - other communication error latches communication bit 1
// - back-channel fault reported as own-phase communication fault
// - communication summary is OR of its flags
// - individual clears also clear summary bits
// - set origin bit when alert_originator_flag
// - origin bit zero when alert idle or late
// - temperature and communication flags kept per phase
// - miscellaneous register shared; bits 7..1 zero
// - alert raised only by unmasked flags
// - byte read and write at 7D, 7E, 7F
// - vendor register phased, write-one and clear-all clearable
// - write to read-only code flags bad command
module pmbus_status_flags
    import pmbus_status_pkg::*;
#(
    parameter int NUM_PHASES = 4
) (
    // system clock and reset
    input  wire logic                                  sys_clk,
    input  wire logic                                  reset_n,
    // link side, on the link clock
    input  wire logic                                  link_clk,
    input  wire logic                                  req_valid,
    input  wire pmbus_status_pkg::link_req_type        req,
    output logic                                       req_busy,
    output logic                                       rsp_valid,
    output logic [7:0]                                 rsp_data,
    // events and masks from the device, on sys_clk
    input  wire pmbus_status_pkg::phase_event_type [NUM_PHASES-1:0] events,
    input  wire logic                                  ro_write_event,
    input  wire logic [7:0]                            temp_mask,
    input  wire logic [7:0]                            cml_mask,
    input  wire logic [7:0]                            vendor_mask,
    // status byte summary bits for the selected phase
    output logic                                       cml_summary,
    output logic                                       misc_summary,
    // shared open-drain alert line, active low
    input  wire logic                                  alert_in,
    output logic                                       alert_out,
    output logic                                       alert_oe
);
    import pmbus_status_pkg::*;

    localparam int PW = (NUM_PHASES > 1) ? $clog2(NUM_PHASES) : 1;

    // one-hot states of the request executor
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_APPLY = 3'b010,
        ST_REPLY = 3'b100
    } exec_state_type;

    // latched flag update: clear wins over old value, a new event wins over clear
    function automatic logic [7:0] w1c(input logic [7:0] q, input logic [7:0] set_bits,
                                       input logic [7:0] clr_bits, input logic [7:0] keep);
        w1c = ((q & ~clr_bits) | set_bits) & keep;
    endfunction

    // true when a code is one of the status registers
    function automatic logic known_code(input logic [7:0] code);
        known_code = (code == CMD_TEMP_FLAGS) || (code == CMD_CML_FLAGS) ||
                     (code == CMD_MISC_FLAGS) || (code == CMD_VENDOR_FLAGS);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // link clock domain
    ////////////////////////////////////////////////////////////////////////////////

    link_req_type req_hold_q;      // request held stable while busy
    logic         req_tog_q;       // toggles once per accepted request
    logic         ack_meta_q;      // first stage of ack sync
    logic         ack_sync_q;      // second stage of ack sync
    logic         ack_seen_q;      // last ack level acted upon
    logic [7:0]   reply_q;         // reply byte, sys domain, stable at ack
    logic         ack_tog_q;       // sys domain acknowledge toggle

    // accept a request only while idle
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_hold_q <= '0;
            req_tog_q  <= 1'b0;
        end else if (req_valid && !req_busy) begin
            req_hold_q <= req;
            req_tog_q  <= ~req_tog_q;
        end
    end

    // two-stage sync of the acknowledge toggle
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_meta_q <= 1'b0;
            ack_sync_q <= 1'b0;
        end else begin
            ack_meta_q <= ack_tog_q;
            ack_sync_q <= ack_meta_q;
        end
    end

    // busy from acceptance to the reply pulse; reply byte captured at ack
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_busy   <= 1'b0;
            rsp_valid  <= 1'b0;
            rsp_data   <= 8'h00;
            ack_seen_q <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (req_valid && !req_busy) begin
                req_busy <= 1'b1;
            end else if (ack_sync_q != ack_seen_q) begin
                ack_seen_q <= ack_sync_q;
                req_busy   <= 1'b0;
                rsp_valid  <= 1'b1;
                rsp_data   <= reply_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // system clock domain: request executor
    ////////////////////////////////////////////////////////////////////////////////

    exec_state_type   state_q;         // executor state
    logic             req_meta_q;      // first stage of request sync
    logic             req_sync_q;      // second stage of request sync
    logic             req_seen_q;      // last request level acted upon
    link_req_type     cur_q;           // request being executed
    logic [PW-1:0]    phase_q;         // phase selected by the last request
    logic [7:0]       temp_q   [NUM_PHASES];  // temperature flags per phase
    logic [7:0]       cml_q    [NUM_PHASES];  // communication flags per phase
    logic [7:0]       vendor_q [NUM_PHASES];  // vendor flags per phase
    logic             origin_q;        // alert_originator_flag flag, shared
    logic             alert_meta_q;    // first stage of alert pin sync
    logic             alert_sync_q;    // second stage of alert pin sync

    logic             apply;           // executor applies the request this cycle
    logic             do_write;        // byte write to a status code
    logic             do_clear;        // clear-all command
    logic             bad_code;        // unknown code on a read or write request
    logic [PW-1:0]    req_phase;       // phase index of the current request

    assign apply     = (state_q == ST_APPLY);
    assign do_write  = apply && (cur_q.op == OP_WRITE);
    assign do_clear  = apply && (cur_q.op == OP_CLEAR);
    assign bad_code  = apply && (cur_q.op != OP_CLEAR) && !known_code(cur_q.code);
    assign req_phase = PW'(cur_q.phase % NUM_PHASES);

    // two-stage sync of the request toggle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_meta_q <= 1'b0;
            req_sync_q <= 1'b0;
        end else begin
            req_meta_q <= req_tog_q;
            req_sync_q <= req_meta_q;
        end
    end

    // executor: capture, apply, reply
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q    <= ST_IDLE;
            req_seen_q <= 1'b0;
            cur_q      <= '0;
            ack_tog_q  <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (req_sync_q != req_seen_q) begin
                        req_seen_q <= req_sync_q;
                        cur_q      <= req_hold_q;
                        state_q    <= ST_APPLY;
                    end
                end
                ST_APPLY: begin
                    state_q <= ST_REPLY;
                end
                ST_REPLY: begin
                    ack_tog_q <= ~ack_tog_q;
                    state_q   <= ST_IDLE;
                end
            endcase
        end
    end

    // phase selection follows the last request
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= '0;
        end else if (apply) begin
            phase_q <= req_phase;
        end
    end

    // read mux, captured once the flags have taken the request
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reply_q <= 8'h00;
        end else if (state_q == ST_REPLY) begin
            unique case (cur_q.code)
                CMD_TEMP_FLAGS:   reply_q <= temp_q[phase_q];
                CMD_CML_FLAGS:    reply_q <= cml_q[phase_q];
                CMD_MISC_FLAGS:   reply_q <= {7'h00, origin_q};
                CMD_VENDOR_FLAGS: reply_q <= vendor_q[phase_q] |
                                  ({7'h00, events[phase_q].self_busy} << SELF_CHECK_BIT);
                default:          reply_q <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // system clock domain: latched flags
    ////////////////////////////////////////////////////////////////////////////////

    // per-phase flag registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int p = 0; p < NUM_PHASES; p++) begin
                temp_q[p]   <= TEMP_RESET;
                cml_q[p]    <= CML_RESET;
                vendor_q[p] <= VENDOR_RESET;
            end
        end else begin
            for (int p = 0; p < NUM_PHASES; p++) begin
                logic       hit;
                logic [7:0] tset;
                logic [7:0] cset;
                logic [7:0] vset;
                hit  = (PW'(p) == req_phase);
                tset = 8'h00;
                cset = 8'h00;
                vset = 8'h00;
                tset[OVERTEMP_FAULT_BIT] = events[p].ot_fault;
                tset[OVERTEMP_WARN_BIT]  = events[p].ot_warn;
                cset[BAD_COMMAND_BIT]    = events[p].bad_command |
                                           (bad_code && hit) |
                                           (ro_write_event && PW'(p) == phase_q);
                cset[BAD_PAYLOAD_BIT]    = events[p].bad_payload;
                cset[PEC_FAIL_BIT]       = events[p].pec_fail;
                cset[MEMORY_ERROR_BIT]   = events[p].mem_error;
                cset[CORE_LOGIC_BIT]     = events[p].core_error;
                cset[LINK_ERROR_BIT]     = events[p].link_error |
                                           events[p].backchannel_fault;
                vset[POWER_ON_FAULT_BIT] = events[p].por_fault;
                vset[RESET_EVENT_BIT]    = events[p].reset_event;
                vset[BACKCHANNEL_BIT]    = events[p].backchannel_fault;
                vset[SYNC_FAULT_BIT]     = events[p].sync_fault;
                temp_q[p] <= w1c(temp_q[p], tset,
                    do_clear ? 8'hFF :
                    (do_write && hit && cur_q.code == CMD_TEMP_FLAGS) ? cur_q.data : 8'h00,
                    TEMP_SUPPORTED);
                cml_q[p] <= w1c(cml_q[p], cset,
                    do_clear ? 8'hFF :
                    (do_write && hit && cur_q.code == CMD_CML_FLAGS) ? cur_q.data : 8'h00,
                    CML_SUPPORTED);
                vendor_q[p] <= w1c(vendor_q[p], vset,
                    do_clear ? 8'hFF :
                    (do_write && hit && cur_q.code == CMD_VENDOR_FLAGS) ? cur_q.data : 8'h00,
                    VENDOR_SUPPORTED);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // alert and alert_originator_flag
    ////////////////////////////////////////////////////////////////////////////////

    logic alert_want;   // some unmasked flag is set in any phase
    logic origin_clr;   // write-one or clear-all on the origin bit

    // unmasked flags only; the origin bit itself never raises the alert
    always_comb begin
        alert_want = 1'b0;
        for (int p = 0; p < NUM_PHASES; p++) begin
            alert_want = alert_want | (|(temp_q[p] & ~temp_mask)) |
                         (|(cml_q[p] & ~cml_mask)) | (|(vendor_q[p] & ~vendor_mask));
        end
    end

    assign origin_clr = do_clear ||
                        (do_write && cur_q.code == CMD_MISC_FLAGS && cur_q.data[ALERT_ORIGIN_BIT]);

    // two-stage sync of the shared alert line
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            alert_meta_q <= 1'b1;
            alert_sync_q <= 1'b1;
        end else begin
            alert_meta_q <= alert_in;
            alert_sync_q <= alert_meta_q;
        end
    end

    // drive the line low while an unmasked flag stands
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            alert_oe  <= 1'b0;
            alert_out <= 1'b0;
        end else begin
            alert_oe  <= alert_want;
            alert_out <= 1'b0;
        end
    end

    // origin set when we start pulling an idle line; dropped when our alert ends
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            origin_q <= MISC_RESET[ALERT_ORIGIN_BIT];
        end else if (alert_want && !alert_oe && alert_sync_q) begin
            origin_q <= 1'b1;
        end else if (!alert_want || origin_clr) begin
            origin_q <= 1'b0;
        end
    end

    // status byte summary bits for the selected phase
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cml_summary  <= 1'b0;
            misc_summary <= 1'b0;
        end else begin
            cml_summary  <= |cml_q[phase_q];
            misc_summary <= origin_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    ////////////////////////////////////////////////////////////////////////////////

    logic cml_sel_any;  // any communication flag of the selected phase
    assign cml_sel_any = |cml_q[phase_q];

    sequence s_clear_all;
        do_clear;
    endsequence

    sequence s_flags_gone;
        (temp_q[0] == 8'h00) ##0 (cml_q[0] == 8'h00) ##0 (vendor_q[0] == 8'h00);
    endsequence

    a_otf_latch: assert property (@(posedge sys_clk) disable iff (!reset_n)
        events[0].ot_fault |=> temp_q[0][OVERTEMP_FAULT_BIT])
        else $error("overtemp fault flag did not latch");

    a_otw_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
        temp_q[0][OVERTEMP_WARN_BIT] && !do_write && !do_clear
        |=> temp_q[0][OVERTEMP_WARN_BIT])
        else $error("overtemp warn flag dropped without clear");

    a_unsup_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ((temp_q[0] & ~TEMP_SUPPORTED) == 8'h00) && ((cml_q[0] & ~CML_SUPPORTED) == 8'h00))
        else $error("unsupported flag position is set");

    a_clear_all: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_clear_all ##0 (events[0] == '0) ##0 !ro_write_event |=> s_flags_gone)
        else $error("clear-all left a flag set");

    a_bad_code: assert property (@(posedge sys_clk) disable iff (!reset_n)
        bad_code |=> cml_q[$past(req_phase)][BAD_COMMAND_BIT])
        else $error("unknown command not flagged");

    a_summary_or: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ##1 cml_summary == $past(cml_sel_any))
        else $error("summary bit disagrees with flags");

    a_alert_mask: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(alert_oe) |-> $past(alert_want) && !$past(alert_oe))
        else $error("alert raised without unmasked flag");

    a_origin_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !alert_want |=> !origin_q)
        else $error("origin flag set while alert idle");

    a_set_wins: assert property (@(posedge sys_clk) disable iff (!reset_n)
        events[0].pec_fail && (do_clear || do_write) |=> cml_q[0][PEC_FAIL_BIT])
        else $error("event lost to a simultaneous clear");

    a_reply_ack: assert property (@(posedge sys_clk) disable iff (!reset_n)
        apply |=> (state_q == ST_REPLY) ##1 (ack_tog_q != $past(ack_tog_q)))
        else $error("request not acknowledged in two cycles");

endmodule // pmbus_status_flags

// ===== hdl/pmbus_status_pkg.sv
// latched status flag registers: shared constants, codes and carrier types
// assumes: one command is carried per request; phase numbers fit the phase byte
package pmbus_status_pkg;

    // command codes of the status registers
    localparam logic [7:0] CMD_TEMP_FLAGS   = 8'h7D;
    localparam logic [7:0] CMD_CML_FLAGS    = 8'h7E;
    localparam logic [7:0] CMD_MISC_FLAGS   = 8'h7F;
    localparam logic [7:0] CMD_VENDOR_FLAGS = 8'h80;

    // reset values
    localparam logic [7:0] TEMP_RESET   = 8'h00;
    localparam logic [7:0] CML_RESET    = 8'h00;
    localparam logic [7:0] MISC_RESET   = 8'h00;
    localparam logic [7:0] VENDOR_RESET = 8'h00;

    // field positions, temperature flags
    localparam int OVERTEMP_FAULT_BIT = 7;
    localparam int OVERTEMP_WARN_BIT  = 6;
    // field positions, communication / logic / memory flags
    localparam int BAD_COMMAND_BIT    = 7;
    localparam int BAD_PAYLOAD_BIT    = 6;
    localparam int PEC_FAIL_BIT       = 5;
    localparam int MEMORY_ERROR_BIT   = 4;
    localparam int CORE_LOGIC_BIT     = 3;
    localparam int LINK_ERROR_BIT     = 1;
    // field positions, miscellaneous and vendor flags
    localparam int ALERT_ORIGIN_BIT   = 0;
    localparam int POWER_ON_FAULT_BIT = 7;
    localparam int SELF_CHECK_BIT     = 6;
    localparam int RESET_EVENT_BIT    = 3;
    localparam int BACKCHANNEL_BIT    = 2;
    localparam int SYNC_FAULT_BIT     = 1;

    // supported (latched) positions; everything else reads zero, save vendor bit 6 (self_busy, read live)
    localparam logic [7:0] TEMP_SUPPORTED   = 8'hC0;
    localparam logic [7:0] CML_SUPPORTED    = 8'hFA;
    localparam logic [7:0] MISC_SUPPORTED   = 8'h01;
    localparam logic [7:0] VENDOR_SUPPORTED = 8'h8E;

    // request kinds on the link
    typedef enum logic [1:0] {
        OP_READ  = 2'h0,
        OP_WRITE = 2'h1,
        OP_CLEAR = 2'h2
    } link_op_type;

    // one request from the link side
    typedef struct packed {
        link_op_type op;
        logic [7:0]  code;
        logic [7:0]  data;
        logic [7:0]  phase;
    } link_req_type;

    // per-phase events from the power stage logic (one-cycle pulses, self_busy a level)
    typedef struct packed {
        logic ot_fault;
        logic ot_warn;
        logic bad_command;
        logic bad_payload;
        logic pec_fail;
        logic mem_error;
        logic core_error;
        logic link_error;
        logic backchannel_fault;
        logic por_fault;
        logic reset_event;
        logic sync_fault;
        logic self_busy;
    } phase_event_type;

endpackage

// ===== test/pmbus_link_host.sv
// link-side host model: one request at a time on the link clock
// assumes: the design answers each taken request with a one-cycle rsp_valid
`timescale 1ns/1ps
module pmbus_link_host
    import pmbus_status_pkg::*;
(
    // link clock and answer from the design
    input  wire logic                          link_clk,
    input  wire logic                          rsp_valid,
    input  wire logic [7:0]                    rsp_data,
    // request towards the design
    output pmbus_status_pkg::link_req_type     req,
    output logic                               req_valid
);
    int lost = 0;  // requests that got no reply in time
    // idle bus at start
    initial begin
        req_valid = 1'b0;
        req       = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////////////
    // one-byte transfer: pulse the request, wait a bounded time for the reply
    task automatic xfer(input link_op_type op, input logic [7:0] code, input logic [7:0] data,
                        input logic [7:0] phase, output logic [7:0] rd);
        int n;
        n = 0;
        @(negedge link_clk);
        req_valid = 1'b1;
        req       = '{op, code, data, phase};
        @(negedge link_clk);
        req_valid = 1'b0;
        // reply edge; gives up after a bounded wait
        while (rsp_valid !== 1'b1 && n < 20) begin
            @(negedge link_clk);
            n++;
        end
        // a missing reply counts against the run
        if (rsp_valid !== 1'b1) begin
            lost++;
        end
        rd  = rsp_data;
        // released request lines show a changing pattern, not the old value
        req = ~req;
    endtask
endmodule // pmbus_link_host

// ===== test/tb_pmbus_status_flags.sv
// testbench of the latched status flag block, four phases
// assumes: host model on the link clock; events driven at sys_clk falling edge
`timescale 1ns/1ps
module tb_pmbus_status_flags;
    import pmbus_status_pkg::*;
    logic                        sys_clk = 1'b0;    // 50 ns system clock
    logic                        link_clk = 1'b0;   // 160 ns link clock
    logic                        reset_n = 1'b0;    // active-low reset
    link_req_type                req;               // request from host model
    logic                        req_valid, req_busy, rsp_valid, cml_summary, misc_summary;
    logic [7:0]                  rsp_data, rd;      // reply byte, last read
    phase_event_type [3:0]       events = '0;       // per-phase event pulses
    logic                        ro_write_event = 1'b0;
    logic [7:0]                  temp_mask = 8'h00, cml_mask = 8'h00; // alert masks
    logic                        alert_out, alert_oe, alert_in;
    logic                        other_pull = 1'b0; // another device pulling alert
    int                          err_count = 0;
    int                          num_checks = 0;
    // open-drain alert wire with pull-up
    assign alert_in = ~(alert_oe | other_pull);
    always #25 sys_clk = ~sys_clk;
    initial begin
        #13;
        forever #80 link_clk = ~link_clk;
    end
    pmbus_status_flags #(.NUM_PHASES(4)) u_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .link_clk(link_clk), .req_valid(req_valid),
        .req(req), .req_busy(req_busy), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .events(events), .ro_write_event(ro_write_event), .temp_mask(temp_mask),
        .cml_mask(cml_mask), .vendor_mask(8'h00), .cml_summary(cml_summary),
        .misc_summary(misc_summary), .alert_in(alert_in), .alert_out(alert_out),
        .alert_oe(alert_oe));
    pmbus_link_host u_host (
        .link_clk(link_clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .req(req), .req_valid(req_valid));
    ////////////////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // one-cycle event pulse on a phase, then let it settle
    task automatic pulse(input int ph, input logic [12:0] ev);
        @(negedge sys_clk);
        events[ph] = ev;
        @(negedge sys_clk);
        events[ph] = '0;
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic clear_all();
        u_host.xfer(OP_CLEAR, 8'h00, 8'h00, 8'h00, rd);
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    // temperature flags, per-phase, write-one clear, alert masking
    task automatic test_temp();
        pulse(0, 13'h1800);
        check({7'h00, alert_oe}, 8'h01);
        u_host.xfer(OP_READ, CMD_TEMP_FLAGS, 8'h00, 8'h00, rd);
        check(rd, 8'hC0);
        check({6'h00, req_busy, alert_out}, 8'h00);
        u_host.xfer(OP_READ, CMD_TEMP_FLAGS, 8'h00, 8'h01, rd);
        check(rd, 8'h00);
        u_host.xfer(OP_WRITE, CMD_TEMP_FLAGS, 8'hBF, 8'h00, rd);
        u_host.xfer(OP_READ, CMD_TEMP_FLAGS, 8'h00, 8'h00, rd);
        check(rd, 8'h40);
        clear_all();
        @(negedge sys_clk);
        temp_mask = 8'hFF;
        pulse(0, 13'h1000);
        check({7'h00, alert_oe}, 8'h00);
        u_host.xfer(OP_READ, CMD_TEMP_FLAGS, 8'h00, 8'h00, rd);
        check(rd, 8'h80);
        clear_all();
        @(negedge sys_clk);
        temp_mask = 8'h00;
        $display("test temp done");
    endtask
    // every communication flag, back-channel fault, summary bit
    task automatic test_cml();
        logic [7:0] exp [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h02};
        for (int i = 0; i < 7; i++) begin
            pulse(1, 13'(1) << (10 - i));
            u_host.xfer(OP_READ, CMD_CML_FLAGS, 8'h00, 8'h01, rd);
            check(rd, exp[i]);
            repeat (3) @(negedge sys_clk);
            check({7'h00, cml_summary}, 8'h01);
            u_host.xfer(OP_WRITE, CMD_CML_FLAGS, 8'hFF, 8'h01, rd);
            u_host.xfer(OP_READ, CMD_CML_FLAGS, 8'h00, 8'h01, rd);
            check(rd, 8'h00);
            repeat (3) @(negedge sys_clk);
            check({7'h00, cml_summary}, 8'h00);
        end
        u_host.xfer(OP_READ, CMD_VENDOR_FLAGS, 8'h00, 8'h01, rd);
        check(rd, 8'h04);
        clear_all();
        u_host.xfer(OP_READ, CMD_VENDOR_FLAGS, 8'h00, 8'h01, rd);
        check(rd, 8'h00);
        $display("test cml done");
    endtask
    // alert_originator_flag: own first, cleared, and beaten by another device
    task automatic test_origin();
        pulse(2, 13'h1000);
        u_host.xfer(OP_READ, CMD_MISC_FLAGS, 8'h00, 8'h03, rd);
        check(rd, 8'h01);
        u_host.xfer(OP_WRITE, CMD_MISC_FLAGS, 8'hFE, 8'h03, rd);
        u_host.xfer(OP_READ, CMD_MISC_FLAGS, 8'h00, 8'h01, rd);
        check(rd, 8'h01);
        check({7'h00, misc_summary}, 8'h01);
        clear_all();
        u_host.xfer(OP_READ, CMD_MISC_FLAGS, 8'h00, 8'h00, rd);
        check(rd, 8'h00);
        other_pull = 1'b1;
        repeat (4) @(negedge sys_clk);
        pulse(2, 13'h1000);
        u_host.xfer(OP_READ, CMD_MISC_FLAGS, 8'h00, 8'h00, rd);
        check(rd, 8'h00);
        other_pull = 1'b0;
        clear_all();
        $display("test origin done");
    endtask
    // write to a read-only code and a read of an unknown code both flag a bad command
    task automatic test_bad_cmd();
        @(negedge sys_clk);
        cml_mask       = 8'hFF;
        ro_write_event = 1'b1;
        @(negedge sys_clk);
        ro_write_event = 1'b0;
        u_host.xfer(OP_READ, CMD_CML_FLAGS, 8'h00, 8'h00, rd);
        check(rd, 8'h80);
        check({7'h00, alert_oe}, 8'h00);
        u_host.xfer(OP_READ, 8'h55, 8'h00, 8'h02, rd);
        check(rd, 8'h00);
        u_host.xfer(OP_READ, CMD_CML_FLAGS, 8'h00, 8'h02, rd);
        check(rd, 8'h80);
        clear_all();
        @(negedge sys_clk);
        cml_mask = 8'h00;
        $display("test bad command done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    // counts and verdict, the one place where the run ends
    task automatic end_of_test();
        err_count = err_count + u_host.lost;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (20) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (3) @(posedge link_clk);
        test_temp();
        test_cml();
        test_origin();
        test_bad_cmd();
        end_of_test();
    end
    // watchdog, far beyond the roughly 50 us the tests need
    initial begin
        #400000;
        err_count++;
        end_of_test();
    end
endmodule // tb_pmbus_status_flags
